// ### rtl/cal_field.sv
`timescale 1ns/1ps
// One register field with reset value, software write, hardware load and wake restore
module cal_field #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic sw_wr_i,
    input wire logic [W-1:0] sw_data_i,
    input wire logic hw_ld_i,
    input wire logic [W-1:0] hw_data_i,
    input wire logic restore_i,
    output logic [W-1:0] value_o
);
    logic [W-1:0] value_ff;

    // Software write wins over a hardware result in the same cycle: the override stands
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            value_ff <= RST;
        end else if (restore_i) begin
            value_ff <= RST;
        end else if (sw_wr_i) begin
            value_ff <= sw_data_i;
        end else if (hw_ld_i) begin
            value_ff <= hw_data_i;
        end
    end

    assign value_o = value_ff;
endmodule : cal_field

// ### rtl/synth_cal_pkg.sv
// Package: offsets, field layouts and reset values of the synthesizer calibration bank
package synth_cal_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    localparam logic [15:0] VCO_CURRENT_OFFS = 16'hdf1d;
    localparam logic [15:0] COARSE_CAP_OFFS = 16'hdf1e;
    localparam logic [15:0] CAL_CONTROL_OFFS = 16'hdf1f;
    localparam logic [15:0] TUNE_A_OFFS = 16'hdf23;
    localparam logic [15:0] TUNE_B_OFFS = 16'hdf24;
    localparam logic [15:0] CAL_OPTIONS_OFFS = 16'hdf25;

    localparam int CORE_SEL_BIT = 5;
    localparam int CHOICE_STAGE_BIT = 1;

    localparam logic [4:0] VCO_CURRENT_RST = 5'h0a;
    localparam logic CORE_SEL_RST = 1'h0;
    localparam logic [5:0] COARSE_CAP_RST = 6'h20;
    localparam logic [6:0] CAL_CONTROL_RST = 7'h0d;
    localparam logic [7:0] TUNE_A_RST = 8'h88;
    localparam logic [7:0] TUNE_B_RST = 8'h11;
    localparam logic [7:0] CAL_OPTIONS_RST = 8'h0b;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // Results delivered by the calibration sequencer
    typedef struct packed {
        logic vco_current_load;
        logic [4:0] vco_current;
        logic coarse_cap_load;
        logic [5:0] coarse_cap;
    } cal_result_type;

    // Settings presented to the analogue synthesizer
    typedef struct packed {
        logic vco_core_select;
        logic [4:0] vco_current;
        logic [5:0] coarse_cap;
        logic [6:0] cal_control;
        logic [7:0] low_rate_tune_a;
        logic [7:0] low_rate_tune_b;
        logic vco_choice_cal_stage_on;
        logic [7:0] vco_cal_options;
    } synth_cfg_type;
endpackage : synth_cal_pkg

// ### rtl/synth_calibration_regs.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Synthesizer calibration result, control and test tuning register bank

// Overview of operation
// - Core select bit picks low core at 0, high at 1; resets 0.
// - Five-bit VCO current holds calibration result, resets 01010, writes override it.
// - Six-bit coarse tuning holds capacitor setting, writable, resets 100000.
// - Coarse tuning returns to reset value on wake from the deepest power modes.
// - Seven-bit calibration control is read/write, resets 0001101.
// - Options bit 1 enables the VCO choice calibration stage; resets 1.
// - Options upper six bits reset 000010, bit 0 resets 1; stored as written.
module synth_calibration_regs
    import synth_cal_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire synth_cal_pkg::reg_req_type req_i,
    output logic [7:0] rdata_o,
    input wire synth_cal_pkg::cal_result_type result_i,
    input wire logic deep_wake_i,
    output synth_cal_pkg::synth_cfg_type cfg_o
);
    import synth_cal_pkg::*;

    // Priority inside every field: wake restore, then software write, then a
    // sequencer load. A software write is the override, so it must beat a result
    // that arrives in the same cycle. The restore beats both because the analogue
    // side has lost its tuning state on wake; software that saved coarse values
    // for fast hopping has to write them again after every wake. Only the coarse
    // field is restored; the current field and all other registers keep their
    // values. The core select bit is stored like any other bit, although only the
    // low core is meant to be used. Strobes may come back to back, and write and
    // read strobes are never high together, so no arbitration is needed here.

    // Write byte cut into the stored fields; bits above a field are dropped
    logic [7:0] wdata_byte;
    logic wdata_core_sel;
    logic [4:0] wdata_current;
    logic [5:0] wdata_coarse;
    logic [6:0] wdata_control;
    logic [5:0] wdata_opt_upper;
    logic wdata_stage;
    logic wdata_opt_trim;

    // Register selects from the address; the offsets differ, so at most one is high
    logic sel_current;
    logic sel_coarse;
    logic sel_control;
    logic sel_tune_a;
    logic sel_tune_b;
    logic sel_options;

    // Write enables for each register
    logic wr_current;
    logic wr_coarse;
    logic wr_control;
    logic wr_tune_a;
    logic wr_tune_b;
    logic wr_options;

    // Read enables for each register
    logic rd_current;
    logic rd_coarse;
    logic rd_control;
    logic rd_tune_a;
    logic rd_tune_b;
    logic rd_options;

    // Calibration sequencer results and the wake restore
    logic ld_current;
    logic [4:0] ld_current_data;
    logic ld_coarse;
    logic [5:0] ld_coarse_data;
    logic restore_coarse;

    // Stored field values
    logic [4:0] vco_current;
    logic [5:0] coarse_cap;
    logic core_sel;
    logic [6:0] cal_control;
    logic [7:0] tune_a;
    logic [7:0] tune_b;
    logic [5:0] opt_upper;
    logic stage_on;
    logic opt_trim;
    logic [7:0] options;

    // Register words as software reads them
    logic [7:0] word_current;
    logic [7:0] word_coarse;
    logic [7:0] word_control;
    logic [7:0] word_tune_a;
    logic [7:0] word_tune_b;
    logic [7:0] word_options;

    // Read path
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    // Field slices of the write byte
    always_comb begin
        wdata_byte = req_i.wdata;
        wdata_core_sel = req_i.wdata[CORE_SEL_BIT];
        wdata_current = req_i.wdata[4:0];
        wdata_coarse = req_i.wdata[5:0];
        wdata_control = req_i.wdata[6:0];
        wdata_opt_upper = req_i.wdata[7:2];
        wdata_stage = req_i.wdata[CHOICE_STAGE_BIT];
        wdata_opt_trim = req_i.wdata[0];
    end

    // Address decode shared by the write and the read path
    always_comb begin
        sel_current = 1'b0;
        sel_coarse = 1'b0;
        sel_control = 1'b0;
        sel_tune_a = 1'b0;
        sel_tune_b = 1'b0;
        sel_options = 1'b0;
        if (req_i.addr == VCO_CURRENT_OFFS) begin
            sel_current = 1'b1;
        end else if (req_i.addr == COARSE_CAP_OFFS) begin
            sel_coarse = 1'b1;
        end else if (req_i.addr == CAL_CONTROL_OFFS) begin
            sel_control = 1'b1;
        end else if (req_i.addr == TUNE_A_OFFS) begin
            sel_tune_a = 1'b1;
        end else if (req_i.addr == TUNE_B_OFFS) begin
            sel_tune_b = 1'b1;
        end else if (req_i.addr == CAL_OPTIONS_OFFS) begin
            sel_options = 1'b1;
        end
    end

    // A write to an unmapped address selects nothing and is ignored
    always_comb begin
        wr_current = req_i.wr && sel_current;
        wr_coarse = req_i.wr && sel_coarse;
        wr_control = req_i.wr && sel_control;
        wr_tune_a = req_i.wr && sel_tune_a;
        wr_tune_b = req_i.wr && sel_tune_b;
        wr_options = req_i.wr && sel_options;
    end

    // Reads have no side effect, so the enables only steer the read mux
    always_comb begin
        rd_current = req_i.rd && sel_current;
        rd_coarse = req_i.rd && sel_coarse;
        rd_control = req_i.rd && sel_control;
        rd_tune_a = req_i.rd && sel_tune_a;
        rd_tune_b = req_i.rd && sel_tune_b;
        rd_options = req_i.rd && sel_options;
    end

    // Sequencer loads arrive as single-cycle pulses alongside their result
    always_comb begin
        ld_current = result_i.vco_current_load;
        ld_current_data = result_i.vco_current;
        ld_coarse = result_i.coarse_cap_load;
        ld_coarse_data = result_i.coarse_cap;
        restore_coarse = deep_wake_i;
    end

    // Calibration result; a software write overrides it
    cal_field #(
        .W(5),
        .RST(VCO_CURRENT_RST)
    ) cal_field_current_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_current),
        .sw_data_i(wdata_current),
        .hw_ld_i(ld_current),
        .hw_data_i(ld_current_data),
        .restore_i(1'b0),
        .value_o(vco_current)
    );

    // Coarse tuning, reset on deep wake so saved values are lost
    cal_field #(
        .W(6),
        .RST(COARSE_CAP_RST)
    ) cal_field_coarse_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_coarse),
        .sw_data_i(wdata_coarse),
        .hw_ld_i(ld_coarse),
        .hw_data_i(ld_coarse_data),
        .restore_i(restore_coarse),
        .value_o(coarse_cap)
    );

    // Core select shares the current register but is never loaded by hardware
    cal_field #(
        .W(1),
        .RST(CORE_SEL_RST)
    ) cal_field_core_sel_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_current),
        .sw_data_i(wdata_core_sel),
        .hw_ld_i(1'b0),
        .hw_data_i(1'b0),
        .restore_i(1'b0),
        .value_o(core_sel)
    );

    // Calibration control, software only
    cal_field #(
        .W(7),
        .RST(CAL_CONTROL_RST)
    ) cal_field_control_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_control),
        .sw_data_i(wdata_control),
        .hw_ld_i(1'b0),
        .hw_data_i('0),
        .restore_i(1'b0),
        .value_o(cal_control)
    );

    // First tuning register, all eight bits stored
    cal_field #(
        .W(8),
        .RST(TUNE_A_RST)
    ) cal_field_tune_a_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_tune_a),
        .sw_data_i(wdata_byte),
        .hw_ld_i(1'b0),
        .hw_data_i('0),
        .restore_i(1'b0),
        .value_o(tune_a)
    );

    // Second tuning register; its reset value is not the one software must use
    cal_field #(
        .W(8),
        .RST(TUNE_B_RST)
    ) cal_field_tune_b_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_tune_b),
        .sw_data_i(wdata_byte),
        .hw_ld_i(1'b0),
        .hw_data_i('0),
        .restore_i(1'b0),
        .value_o(tune_b)
    );

    // Upper options bits, stored and read back as written
    cal_field #(
        .W(6),
        .RST(CAL_OPTIONS_RST[7:2])
    ) cal_field_opt_upper_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_options),
        .sw_data_i(wdata_opt_upper),
        .hw_ld_i(1'b0),
        .hw_data_i('0),
        .restore_i(1'b0),
        .value_o(opt_upper)
    );

    // Choice stage enable; clearing it skips that calibration stage
    cal_field #(
        .W(1),
        .RST(CAL_OPTIONS_RST[CHOICE_STAGE_BIT])
    ) cal_field_stage_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_options),
        .sw_data_i(wdata_stage),
        .hw_ld_i(1'b0),
        .hw_data_i(1'b0),
        .restore_i(1'b0),
        .value_o(stage_on)
    );

    // Lowest options bit, stored and read back as written
    cal_field #(
        .W(1),
        .RST(CAL_OPTIONS_RST[0])
    ) cal_field_opt_trim_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sw_wr_i(wr_options),
        .sw_data_i(wdata_opt_trim),
        .hw_ld_i(1'b0),
        .hw_data_i(1'b0),
        .restore_i(1'b0),
        .value_o(opt_trim)
    );

    // Register words; unused upper bits are forced to zero
    always_comb begin
        word_current = {2'h0, core_sel, vco_current};
        word_coarse = {2'h0, coarse_cap};
        word_control = {1'h0, cal_control};
        word_tune_a = tune_a;
        word_tune_b = tune_b;
        word_options = options;
    end

    // Read mux: only an active read strobe puts a word on the bus, else zero
    always_comb begin
        nxt_rdata = UNMAPPED_READ;
        if (rd_current) begin
            nxt_rdata = word_current;
        end else if (rd_coarse) begin
            nxt_rdata = word_coarse;
        end else if (rd_control) begin
            nxt_rdata = word_control;
        end else if (rd_tune_a) begin
            nxt_rdata = word_tune_a;
        end else if (rd_tune_b) begin
            nxt_rdata = word_tune_b;
        end else if (rd_options) begin
            nxt_rdata = word_options;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_ff <= UNMAPPED_READ;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;

    // Options register reassembled from its three fields
    always_comb begin
        options = {opt_upper, stage_on, opt_trim};
    end

    // Calibration fields as the synthesizer uses them
    always_comb begin
        cfg_o.vco_core_select = core_sel;
        cfg_o.vco_current = vco_current;
        cfg_o.coarse_cap = coarse_cap;
        cfg_o.cal_control = cal_control;
        cfg_o.low_rate_tune_a = tune_a;
        cfg_o.low_rate_tune_b = tune_b;
        cfg_o.vco_choice_cal_stage_on = stage_on;
        cfg_o.vco_cal_options = options;
    end
endmodule : synth_calibration_regs

// ### sim/synth_calibration_regs_asserts.sv
// Port checker for the calibration register bank
`timescale 1ns/1ps
module synth_calibration_regs_asserts
    import synth_cal_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire synth_cal_pkg::reg_req_type req_i,
    input wire logic [7:0] rdata_o,
    input wire synth_cal_pkg::cal_result_type result_i,
    input wire logic deep_wake_i,
    input wire synth_cal_pkg::synth_cfg_type cfg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic wr_cur;
    logic wr_cap;
    assign wr_cur = req_i.wr && req_i.addr == VCO_CURRENT_OFFS;
    assign wr_cap = req_i.wr && req_i.addr == COARSE_CAP_OFFS;
    idle_read_a: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    tune_a_wr_a: assert property (req_i.wr && req_i.addr == TUNE_A_OFFS
        |=> cfg_o.low_rate_tune_a == $past(req_i.wdata)) else $error("tune a write lost");
    tune_b_wr_a: assert property (req_i.wr && req_i.addr == TUNE_B_OFFS
        |=> cfg_o.low_rate_tune_b == $past(req_i.wdata)) else $error("tune b write lost");
    cur_override_a: assert property (wr_cur
        |=> cfg_o.vco_current == $past(req_i.wdata[4:0])
        && cfg_o.vco_core_select == $past(req_i.wdata[CORE_SEL_BIT]))
        else $error("current write lost");
    cur_load_a: assert property (result_i.vco_current_load && !wr_cur
        |=> cfg_o.vco_current == $past(result_i.vco_current)) else $error("current load lost");
    cap_load_a: assert property (result_i.coarse_cap_load && !wr_cap && !deep_wake_i
        |=> cfg_o.coarse_cap == $past(result_i.coarse_cap)) else $error("coarse load lost");
    ctrl_wr_a: assert property (req_i.wr && req_i.addr == CAL_CONTROL_OFFS
        |=> cfg_o.cal_control == $past(req_i.wdata[6:0])) else $error("control write lost");
    opt_wr_a: assert property (req_i.wr && req_i.addr == CAL_OPTIONS_OFFS
        |=> cfg_o.vco_cal_options == $past(req_i.wdata)) else $error("options write lost");
    cap_restore_a: assert property (deep_wake_i |=> cfg_o.coarse_cap == COARSE_CAP_RST)
        else $error("coarse not restored on wake");
    stage_bit_a: assert property (cfg_o.vco_choice_cal_stage_on == cfg_o.vco_cal_options[1])
        else $error("stage enable differs from options bit");
    ctrl_read_a: assert property ($past(req_i.rd)
        && $past(req_i.addr) == CAL_CONTROL_OFFS
        |-> rdata_o == {1'b0, cfg_o.cal_control}) else $error("control readback wrong");
endmodule : synth_calibration_regs_asserts

bind synth_calibration_regs synth_calibration_regs_asserts synth_calibration_regs_asserts_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .result_i(result_i), .deep_wake_i(deep_wake_i), .cfg_o(cfg_o));

// ### sim/synth_calibration_regs_test.sv
// Testbench for the calibration register bank
`timescale 1ns/1ps
module synth_calibration_regs_test;
    import synth_cal_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    reg_req_type req = '0;
    cal_result_type res = '0;
    logic deep_wake = 1'b0;
    logic [7:0] rdata;
    synth_cfg_type cfg;
    int num_errors = 0;
    int checks = 0;
    logic [15:0] offs [6] = '{VCO_CURRENT_OFFS, COARSE_CAP_OFFS, CAL_CONTROL_OFFS,
        TUNE_A_OFFS, TUNE_B_OFFS, CAL_OPTIONS_OFFS};
    logic [7:0] rst_v [6] = '{8'h0a, 8'h20, 8'h0d, 8'h88, 8'h11, 8'h0b};
    // All-ones writes expose any unused bit that is stored by mistake
    logic [7:0] wr_v [6] = '{8'hff, 8'hff, 8'hff, 8'h81, 8'h31, 8'hfd};
    logic [7:0] rd_v [6] = '{8'h3f, 8'h3f, 8'h7f, 8'h81, 8'h31, 8'hfd};
    always #50 clk_i = ~clk_i;
    synth_calibration_regs synth_calibration_regs_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .rdata_o(rdata),
        .result_i(res), .deep_wake_i(deep_wake), .cfg_o(cfg));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask : wr
    // Read data live only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(negedge clk_i);
        check(rdata, exp);
    endtask : rd
    task automatic wrap_up;
        $display("Mismatches %0d, comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 6; i++) rd(offs[i], rst_v[i]);
        check(8'(cfg.vco_choice_cal_stage_on), 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], wr_v[i]);
            rd(offs[i], rd_v[i]);
        end
        check(8'(cfg.vco_choice_cal_stage_on), 8'h00);
        check(cfg.low_rate_tune_b, 8'h31);
        check(8'(cfg.vco_core_select), 8'h01);
        check(8'(cfg.cal_control), 8'h7f);
        check(cfg.low_rate_tune_a, 8'h81);
        check(cfg.vco_cal_options, 8'hfd);
        wr(TUNE_B_OFFS, 8'h35);
        rd(TUNE_B_OFFS, 8'h35);
        wr(16'hdf20, 8'h5a);
        rd(16'hdf20, 8'h00);
        @(posedge clk_i);
        res <= '{1'b1, 5'h15, 1'b1, 6'h2a};
        @(posedge clk_i);
        res <= '0;
        rd(VCO_CURRENT_OFFS, 8'h35);
        rd(COARSE_CAP_OFFS, 8'h2a);
        wr(COARSE_CAP_OFFS, 8'h11);
        wr(VCO_CURRENT_OFFS, 8'h07);
        rd(COARSE_CAP_OFFS, 8'h11);
        rd(VCO_CURRENT_OFFS, 8'h07);
        @(posedge clk_i);
        deep_wake <= 1'b1;
        @(posedge clk_i);
        deep_wake <= 1'b0;
        rd(COARSE_CAP_OFFS, 8'h20);
        rd(VCO_CURRENT_OFFS, 8'h07);
        wrap_up();
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end
endmodule : synth_calibration_regs_test
